// >>> pkg/pipe_reg_pkg.sv
// constants and types shared by the multilevel pipeline register files
package pipe_reg_pkg;

    localparam int WORD_W = 16;
    localparam int NUM_REGS = 8;
    localparam int CODE_W = 4;
    localparam int SEL_W = 3;
    localparam int FIFO_DEPTH = 32;
    localparam int ENTRY_W = CODE_W + WORD_W;

    // value of every storage register and of the output after reset
    localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;

    // load-control codes; 4'h0..4'h7 load one register each
    localparam logic [CODE_W-1:0] LOAD_FIRST_REG = 4'h0;
    localparam logic [CODE_W-1:0] SHIFT_ALL_EIGHT = 4'h8;
    localparam logic [CODE_W-1:0] SHIFT_LOW_FOUR = 4'h9;
    localparam logic [CODE_W-1:0] SHIFT_HIGH_FOUR = 4'ha;
    localparam logic [CODE_W-1:0] SHIFT_PAIR_ONE = 4'hb;
    localparam logic [CODE_W-1:0] SHIFT_PAIR_TWO = 4'hc;
    localparam logic [CODE_W-1:0] SHIFT_PAIR_THREE = 4'hd;
    localparam logic [CODE_W-1:0] SHIFT_PAIR_FOUR = 4'he;
    localparam logic [CODE_W-1:0] HOLD_ALL = 4'hf;

    // where a storage register takes its next value from
    typedef enum logic [2:0] {
        SRC_HOLD = 3'b001,
        SRC_WORD = 3'b010,
        SRC_PREV = 3'b100
    } reg_src_type;

endpackage

// >>> pkg/word_stream_if.sv
// valid/ready word stream between the fifo and the register bank
`timescale 1ns/1ps
interface word_stream_if #(
    parameter int WIDTH = 20
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/word_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // filling side
    word_stream_if.snk push,
    // draining side
    word_stream_if.src pop
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] ONE_CNT = (PTR_W+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    logic [PTR_W:0] count_nxt;
    logic space_r;
    logic empty_r;
    logic do_push;
    logic do_pop;

    assign do_push = push.valid && space_r;
    assign do_pop = pop.ready && !empty_r;
    // kept as a not-full flop so ready leaves the block with no gate
    assign push.ready = space_r;
    assign pop.valid = !empty_r;
    assign pop.data = mem[rd_ptr_r];

    always_comb begin
        count_nxt = count_r;
        if (do_push && !do_pop) begin
            count_nxt = count_r + ONE_CNT;
        end else if (do_pop && !do_push) begin
            count_nxt = count_r - ONE_CNT;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push.data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // flags registered so the ready seen by the source is a flop
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            count_r <= '0;
            space_r <= 1'b1;
            empty_r <= 1'b1;
        end else begin
            count_r <= count_nxt;
            space_r <= (count_nxt != DEPTH_CNT);
            empty_r <= (count_nxt == '0);
        end
    end
endmodule // word_fifo

// >>> verilog/multilevel_pipeline_register.sv
// eight-register multilevel pipeline with input fifo and output select
`timescale 1ns/1ps
module multilevel_pipeline_register
    import pipe_reg_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // word and its load-control code, queued together
    input wire logic [WORD_W-1:0] i_word_in,
    input wire logic [CODE_W-1:0] i_load_ctrl_code,
    input wire logic i_word_valid,
    output logic o_word_ready,
    // bank drain enable; low stalls the bank so the fifo fills
    input wire logic i_bank_enable,
    // output port
    input wire logic [SEL_W-1:0] i_out_select,
    output logic [WORD_W-1:0] o_word_out,
    output logic o_busy
);

    ////////////////////////////////////////////////////////////////////
    // source selection for register idx under a load code
    function automatic reg_src_type reg_source(
        input logic [CODE_W-1:0] code,
        input int idx
    );
        reg_src_type src;
        src = SRC_HOLD;
        if (!code[3]) begin
            if (int'(code[2:0]) == idx) begin
                src = SRC_WORD;
            end
        end else if (code == SHIFT_ALL_EIGHT) begin
            src = (idx == 0) ? SRC_WORD : SRC_PREV;
        end else if (code == SHIFT_LOW_FOUR) begin
            if (idx == 0) begin
                src = SRC_WORD;
            end else if (idx < 4) begin
                src = SRC_PREV;
            end
        end else if (code == SHIFT_HIGH_FOUR) begin
            if (idx == 4) begin
                src = SRC_WORD;
            end else if (idx > 4) begin
                src = SRC_PREV;
            end
        end else if (code != HOLD_ALL) begin
            // pair codes b..e map to pairs 0..3
            if (idx / 2 == int'(code - SHIFT_PAIR_ONE)) begin
                src = (idx % 2 == 0) ? SRC_WORD : SRC_PREV;
            end
        end
        return src;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input fifo
    word_stream_if #(.WIDTH(ENTRY_W)) in_stream ();
    word_stream_if #(.WIDTH(ENTRY_W)) bank_stream ();

    assign in_stream.valid = i_word_valid;
    assign in_stream.data = {i_load_ctrl_code, i_word_in};
    assign o_word_ready = in_stream.ready;
    assign bank_stream.ready = i_bank_enable;

    word_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .push(in_stream),
        .pop(bank_stream)
    );

    ////////////////////////////////////////////////////////////////////
    // register bank
    logic [WORD_W-1:0] bank_r [NUM_REGS];
    logic [WORD_W-1:0] bank_nxt [NUM_REGS];
    logic [CODE_W-1:0] head_code;
    logic [WORD_W-1:0] head_word;
    logic bank_step;

    assign head_code = bank_stream.data[ENTRY_W-1:WORD_W];
    assign head_word = bank_stream.data[WORD_W-1:0];
    // no entry or stalled bank behaves as a hold
    assign bank_step = bank_stream.valid && i_bank_enable;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            reg_src_type src;
            assign src = bank_step ? reg_source(head_code, gi) : SRC_HOLD;

            always_comb begin
                case (src)
                    SRC_WORD: bank_nxt[gi] = head_word;
                    SRC_PREV: bank_nxt[gi] = bank_r[(gi + NUM_REGS - 1)
                                                    % NUM_REGS];
                    default: bank_nxt[gi] = bank_r[gi];
                endcase
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    bank_r[gi] <= REG_RESET;
                end else begin
                    bank_r[gi] <= bank_nxt[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // output multiplexer; registered, so it shows select and bank
    // contents as of the previous edge (one cycle of latency)
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_word_out <= REG_RESET;
        end else begin
            o_word_out <= bank_r[i_out_select];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= bank_step;
        end
    end

endmodule // multilevel_pipeline_register

// >>> bench/pipe_reg_props.sv
// port assertions for the multilevel pipeline register
`timescale 1ns/1ps
module pipe_reg_props
    import pipe_reg_pkg::*;
(
    input logic i_sys_clk, i_rst_n, i_word_valid, o_word_ready,
    input logic i_bank_enable, o_busy, input logic [SEL_W-1:0] i_out_select,
    input logic [WORD_W-1:0] o_word_out
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_reset_out: assert property (
        $rose(i_rst_n) |-> o_word_out == REG_RESET && !o_busy)
        else $error("rst");
    a_reset_ready: assert property (
        $rose(i_rst_n) |-> o_word_ready) else $error("rst ready");
    a_stall_stable: assert property (
        (!i_bank_enable && $stable(i_out_select))[*3] |-> $stable(o_word_out))
        else $error("output moved");
    a_stall_idle: assert property (
        (!i_bank_enable)[*3] |-> !o_busy) else $error("busy stalled");
    a_busy_cause: assert property (
        o_busy |-> $past(i_bank_enable) || $past(i_bank_enable, 2)
        || $past(i_bank_enable, 3)) else $error("busy cause");
    a_fill_cause: assert property (
        $fell(o_word_ready) |-> $past(i_word_valid)) else $error("ready fell");
    a_full_holds: assert property (
        !o_word_ready && !i_bank_enable && !$past(i_bank_enable)
        |=> !o_word_ready) else $error("full lost");
    a_drain_ready: assert property (
        !o_word_ready && i_bank_enable && !i_word_valid
        |-> ##[1:3] o_word_ready) else $error("no drain");
endmodule // pipe_reg_props

// >>> bench/buf_ctrl_model.sv
// controller model queuing word and load-code pairs
`timescale 1ns/1ps
module buf_ctrl_model
    import pipe_reg_pkg::*;
(
    input logic i_sys_clk, i_word_ready, output logic o_valid,
    output logic [WORD_W-1:0] o_word, output logic [CODE_W-1:0] o_code
);
    initial {o_valid, o_code, o_word} = 21'h0f0000;
    // request held until ready is seen at an edge
    task automatic push(input logic [WORD_W-1:0] w,
        input logic [CODE_W-1:0] c, input bit last, output bit ok);
        bit r;
        r = 1'b0;
        {o_valid, o_code, o_word} <= {1'b1, c, w};
        for (int n = 0; n < 100 && !r; n++) begin
            @(negedge i_sys_clk);
            r = i_word_ready;
            @(posedge i_sys_clk);
        end
        ok = r;
        // released word shows its inverse, never the stale value
        if (last) {o_valid, o_word} <= {1'b0, ~w};
    endtask
endmodule // buf_ctrl_model

// >>> bench/multilevel_pipeline_register_tb.sv
// self-checking bench for the multilevel pipeline register
`timescale 1ns/1ps
module multilevel_pipeline_register_tb
    import pipe_reg_pkg::*;
;
    logic clk, rst_n, en, vld, rdy, busy;
    logic [WORD_W-1:0] wrd, dout;
    logic [WORD_W-1:0] expv [NUM_REGS];
    logic [CODE_W-1:0] code;
    logic [SEL_W-1:0] sel;
    int n_mismatch = 0;
    int n_tests = 0;
    bit ok;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    multilevel_pipeline_register multilevel_pipeline_register_inst (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_word_in(wrd),
        .i_load_ctrl_code(code), .i_word_valid(vld), .o_word_ready(rdy),
        .i_bank_enable(en), .i_out_select(sel), .o_word_out(dout),
        .o_busy(busy));
    buf_ctrl_model buf_ctrl_model_inst (.i_sys_clk(clk), .i_word_ready(rdy),
        .o_valid(vld), .o_word(wrd), .o_code(code));
    task automatic check(input logic [WORD_W-1:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // queue one entry, track it, then, if s is nonzero, settle s cycles and scan all registers
    task automatic put(input int c, input logic [WORD_W-1:0] w, input bit rel,
        input int s);
        int lo, hi;
        buf_ctrl_model_inst.push(w, CODE_W'(c), rel, ok);
        if (!ok) begin
            n_mismatch++;
            report_and_stop();
        end
        lo = c < 8 ? c : c < 11 ? 4 * (c / 10)
            : 2 * c - 22;
        hi = c < 8 ? c : c == 8 ? 7
            : c < 11 ? lo + 3 : lo + 1;
        if (c == 15) hi = -1;
        for (int i = hi; i > lo; i--) expv[i] = expv[i - 1];
        if (hi >= lo) expv[lo] = w;
        repeat (s) @(posedge clk);
        for (int i = 0; i < NUM_REGS && s > 0; i++) begin
            sel <= SEL_W'(i);
            @(posedge clk);
            @(negedge clk);
            check(dout, expv[i]);
            @(posedge clk);
        end
    endtask
    task automatic t_reset();
        check(dout, REG_RESET);
        check({14'h0000, rdy, busy}, 16'h0002);
    endtask
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            put(c, 16'h5a00 + 16'(c), 1'b0, 0);
            put(c, 16'hc300 + 16'(c), 1'b1, 4);
        end
    endtask
    // bank stalled: fifo fills and refuses, then drains in order
    task automatic t_fill();
        en <= 1'b0;
        for (int k = 0; k < FIFO_DEPTH; k++)
            put(8, 16'h7700 + 16'(k), k == FIFO_DEPTH - 1, 0);
        repeat (3) @(negedge clk);
        check({15'h0000, rdy}, 16'h0000);
        @(posedge clk);
        en <= 1'b1;
        // first entry applied one edge after enable, busy set at that same edge
        repeat (2) @(negedge clk);
        check({15'h0000, busy}, 16'h0001);
        @(posedge clk);
        put(15, 16'h0ff0, 1'b1, 40);
        @(negedge clk);
        check({15'h0000, busy}, 16'h0000);
    endtask
    initial begin
        {rst_n, en, sel} = 5'b01000;
        foreach (expv[i]) expv[i] = REG_RESET;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        @(posedge clk);
        t_codes();
        t_fill();
        report_and_stop();
    end
endmodule // multilevel_pipeline_register_tb
bind multilevel_pipeline_register pipe_reg_props pipe_reg_props_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_word_valid(i_word_valid),
    .o_word_ready(o_word_ready), .i_bank_enable(i_bank_enable),
    .o_busy(o_busy), .i_out_select(i_out_select), .o_word_out(o_word_out));
